// [fsi_pkg.sv]
/*
 * Constants for the axis fault and status indicator: register offsets,
 * fault code positions, limits and timing.
 * Assumes a 125 MHz pclk; all users refer to names as fsi_pkg::name.
 */
package fsi_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CONTROL = 8'h00;
	localparam logic [7:0] OFF_STATUS  = 8'h04;
	localparam logic [7:0] OFF_FAULTS  = 8'h08;
	localparam logic [7:0] OFF_ADDRESS = 8'h0C;
	localparam logic [7:0] OFF_EDIT    = 8'h10;
	// control bit positions
	localparam int CTL_CLEAR = 0;
	localparam int CTL_RESET = 1;
	localparam int CTL_WARNF = 2;
	// clock and timing, times in ms
	localparam int CLK_HZ        = 125000000;
	localparam int BLINK_MS      = 250;
	localparam int BLINK_CYCLES  = CLK_HZ / 1000 * BLINK_MS;
	localparam int DOUBLE_MS     = 300;
	localparam int DOUBLE_CYCLES = CLK_HZ / 1000 * DOUBLE_MS;
	localparam logic [2:0] START_WAIT = 3'h7;
	// station address limits
	localparam logic [7:0] MAX_MASTER_ADDR = 8'h80;
	localparam logic [7:0] MIN_AXIS_ADDR   = 8'h01;
	// edit steps
	localparam logic [7:0] STEP_FINE   = 8'h01;
	localparam logic [7:0] STEP_COARSE = 8'h0A;
	// factory limits: 100 V and 145 degC
	localparam logic [9:0] UNDERVOLT_V  = 10'h064;
	localparam logic [7:0] MOTOR_TEMP_C = 8'h91;
	// fault vector bit n-1 holds code Fn
	localparam logic [31:0] CLEARABLE_MASK = 32'h0004_9097;
	localparam logic [31:0] RESERVED_MASK  = 32'h0420_0000;
	localparam int BIT_UNDERVOLT = 4;
	localparam int BIT_MOTOR_TMP = 5;
	localparam int BIT_PARAM_SUM = 8;
	localparam int BIT_PROG_SUM  = 9;
	localparam int BIT_WARN_FLT  = 23;
	localparam logic [5:0] CODE_NONE = 6'h00;
	// menu modes
	typedef enum logic [0:0] {MENU_BROWSE = 1'b0, MENU_EDIT = 1'b1} menu_t;
endpackage : fsi_pkg

// [fsi_top.sv]
/*
 * Fault, warning and status indication for a multi-axis drive: station
 * addressing, two-key panel, fault coding and latch, error response,
 * per-axis LEDs and host traffic forwarding; APB register slave.
 * Assumes pins are asynchronous to pclk; host bytes, checksums, bus
 * voltage and motor temperature come from logic on pclk.
 */
// Implementation choices: register access over APB and the address map.
// Behaviour
// R1: forward host traffic to every axis module
// R2: axis addresses descend from master address
// R3: master address at most 128, last at least 1
// R4: station address captured once after power-up
// R5: single up press: item up or plus one
// R6: double up press adds ten
// R7: single down press: item down or minus one
// R8: double down press subtracts ten
// R9: right held plus left confirms and returns
// R10: faulted axis: red steady, green off
// R11: warning: red blinks, green off
// R12: ready and enabled: green steady
// R13: ready not enabled: green blinks
// R14: selected axis: both LEDs blink
// R15: any error opens contact, stage off, brake
// R16: display shows coded error, F00 none
// R17: distinct fault codes, F22 and F27 reserved
// R18: checksum mismatch raises F09 or F10
// R19: fixed undervoltage and motor temperature limits
// R20: warning as fault reports F24
// R21: clearable faults cleared by clear command
// R22: reset with one clearable fault only clears
// R23: one slow blink period, LEDs in phase
// R24: fixed double-press window
`timescale 1ns/1ns
module fsi_top #(
	parameter int NAXES         = 3,
	parameter int BLINK_CYCLES  = fsi_pkg::BLINK_CYCLES,
	parameter int DOUBLE_CYCLES = fsi_pkg::DOUBLE_CYCLES
) (
	// clock and reset
	input  logic                 pclk,
	input  logic                 presetn,
	// apb slave
	input  logic                 psel,
	input  logic                 penable,
	input  logic                 pwrite,
	input  logic [7:0]           paddr,
	input  logic [31:0]          pwdata,
	output logic [31:0]          prdata,
	output logic                 pready,
	output logic                 pslverr,
	// asynchronous pins
	input  logic [31:0]          fault_in,
	input  logic                 key_right,
	input  logic                 key_left,
	input  logic                 reset_key,
	input  logic [NAXES-1:0]     axis_fault,
	input  logic [NAXES-1:0]     axis_warning,
	input  logic [NAXES-1:0]     axis_enabled,
	input  logic [7:0]           addr_strap,
	// on-chip sensing
	input  logic [9:0]           bus_voltage,
	input  logic [7:0]           motor_temp,
	input  logic [15:0]          param_sum,
	input  logic [15:0]          param_sum_ref,
	input  logic [15:0]          prog_sum,
	input  logic [15:0]          prog_sum_ref,
	// host serial bytes
	input  logic                 host_valid,
	input  logic [7:0]           host_addr,
	input  logic [7:0]           host_data,
	// internal link
	output logic                 link_valid,
	output logic [NAXES:0]       link_sel,
	output logic [7:0]           link_data,
	// error response and display
	output logic                 ready_contact,
	output logic                 stage_enable,
	output logic                 brake_release,
	output logic [5:0]           err_code,
	output logic [NAXES-1:0]     led_red,
	output logic [NAXES-1:0]     led_green,
	output logic [8*NAXES-1:0]   axis_addr,
	output logic [7:0]           saved_addr
);
	localparam int P_KR = 32;
	localparam int P_KL = 33;
	localparam int P_RS = 34;
	localparam int P_AF = 35;
	localparam int P_AW = P_AF + NAXES;
	localparam int P_AE = P_AW + NAXES;
	localparam int P_ST = P_AE + NAXES;
	localparam int PW   = P_ST + 8;

	if (NAXES < 1 || NAXES > 127 || BLINK_CYCLES < 1 || DOUBLE_CYCLES < 1) begin : g_bad
		$error("fsi_top parameters out of range");
	end

	typedef struct packed {
		logic [PW-1:0]         s1;
		logic [PW-1:0]         s2;
		logic [PW-1:0]         s3;
		logic [PW-1:0]         pins;
		logic [31:0]           faults;
		logic                  warn_en;
		logic [2:0]            start_cnt;
		logic                  addr_taken;
		logic                  addr_err;
		logic [7:0]            master_addr;
		logic [7:0]            saved;
		logic [NAXES-1:0][7:0] axis_addr;
		logic [31:0]           blink_cnt;
		logic                  blink;
		logic [31:0]           pend_cnt;
		logic                  pend_up;
		logic                  pend_dn;
		fsi_pkg::menu_t        mode;
		logic [7:0]            menu_item;
		logic [7:0]            edit_val;
		logic [31:0]           rdata;
		logic                  pready;
		logic                  pslverr;
		logic                  ready;
		logic                  stage_en;
		logic                  brake_rel;
		logic [5:0]            err_code;
		logic [NAXES-1:0]      red;
		logic [NAXES-1:0]      green;
		logic                  link_valid;
		logic [NAXES:0]        link_sel;
		logic [7:0]            link_data;
	} state_t;

	state_t      q_reg;
	state_t      q_next;
	logic [PW-1:0] press;
	logic        chord;
	logic        act_up;
	logic        act_dn;
	logic        act_up10;
	logic        act_dn10;
	logic        wr_ctrl;
	logic        do_clear;
	logic        do_reset;
	logic [31:0] set_vec;
	logic [31:0] clr_mask;
	logic [5:0]  code;
	logic        sel_fault;
	logic        err_any;

	// saturating edit steps, address kept in 1..128
	function automatic logic [7:0] step_up(input logic [7:0] v, input logic [7:0] s);
		logic [8:0] t;
		t = {1'b0, v} + {1'b0, s};
		step_up = (t > {1'b0, fsi_pkg::MAX_MASTER_ADDR}) ? fsi_pkg::MAX_MASTER_ADDR : t[7:0];
	endfunction : step_up

	function automatic logic [7:0] step_dn(input logic [7:0] v, input logic [7:0] s);
		step_dn = (v > s) ? v - s : fsi_pkg::MIN_AXIS_ADDR;
	endfunction : step_dn

	// next-state logic of the whole block
	always_comb
	begin
		q_next = q_reg;
		act_up = 1'b0;
		act_dn = 1'b0;
		act_up10 = 1'b0;
		act_dn10 = 1'b0;
		sel_fault = 1'b0;
		code = fsi_pkg::CODE_NONE;
		err_any = |q_reg.faults;

		// three-stage sync, level accepted when stages two and three agree
		q_next.s1 = {addr_strap, axis_enabled, axis_warning, axis_fault,
			reset_key, key_left, key_right, fault_in};
		q_next.s2 = q_reg.s1;
		q_next.s3 = q_reg.s2;
		for (int i = 0; i < PW; i++)
			if (q_reg.s2[i] == q_reg.s3[i])
				q_next.pins[i] = q_reg.s3[i];
		press = q_next.pins & ~q_reg.pins;

		// apb: answer one cycle after setup
		q_next.pready = psel & ~penable;
		q_next.pslverr = 1'b0;
		wr_ctrl = psel & penable & q_reg.pready & pwrite & (paddr == fsi_pkg::OFF_CONTROL);
		do_clear = wr_ctrl & pwdata[fsi_pkg::CTL_CLEAR];
		do_reset = (wr_ctrl & pwdata[fsi_pkg::CTL_RESET]) | press[P_RS];
		if (wr_ctrl)
			q_next.warn_en = pwdata[fsi_pkg::CTL_WARNF];

		// station address captured once after reset release
		if (!q_reg.addr_taken) begin
			q_next.start_cnt = q_reg.start_cnt + 3'h1;
			if (q_reg.start_cnt == fsi_pkg::START_WAIT)
			begin
				q_next.addr_taken = 1'b1; // R4
				q_next.master_addr = q_reg.pins[P_ST +: 8];
				q_next.saved = q_reg.pins[P_ST +: 8];
				q_next.addr_err = (q_reg.pins[P_ST +: 8] > fsi_pkg::MAX_MASTER_ADDR) ||
					(q_reg.pins[P_ST +: 8] <= 8'(NAXES)); // R3
			end
		end
		// descending axis addresses
		for (int k = 0; k < NAXES; k++)
			q_next.axis_addr[k] = q_reg.master_addr - 8'(k + 1); // R2

		// fault sources and latch; a set wins over a clear
		set_vec = q_reg.pins[31:0];
		set_vec[fsi_pkg::BIT_UNDERVOLT] |= bus_voltage < fsi_pkg::UNDERVOLT_V; // R19
		set_vec[fsi_pkg::BIT_MOTOR_TMP] |= motor_temp > fsi_pkg::MOTOR_TEMP_C; // R19
		set_vec[fsi_pkg::BIT_PARAM_SUM] |= param_sum != param_sum_ref; // R18
		set_vec[fsi_pkg::BIT_PROG_SUM] |= prog_sum != prog_sum_ref; // R18
		set_vec[fsi_pkg::BIT_WARN_FLT] |= q_reg.warn_en &
			(|q_reg.pins[P_AW +: NAXES]); // R20
		set_vec = set_vec & ~fsi_pkg::RESERVED_MASK; // R17
		clr_mask = '0;
		if (do_clear)
			clr_mask = fsi_pkg::CLEARABLE_MASK; // R21
		if (do_reset) begin
			if (((q_reg.faults & (q_reg.faults - 32'h1)) == '0) &&
				((q_reg.faults & ~fsi_pkg::CLEARABLE_MASK) == '0))
				clr_mask = fsi_pkg::CLEARABLE_MASK; // R22
			else
				clr_mask = '1;
		end
		q_next.faults = (q_reg.faults & ~clr_mask) | set_vec;

		// lowest code first
		for (int i = 31; i >= 0; i--)
			if (q_reg.faults[i])
				code = 6'(i + 1); // R17
		for (int k = 0; k < NAXES; k++)
			if (q_reg.menu_item == 8'(k + 1))
				sel_fault = q_reg.pins[P_AF + k];
		q_next.err_code = (q_reg.menu_item == 8'h00 || sel_fault) ? code
			: fsi_pkg::CODE_NONE; // R16

		// error response
		q_next.ready = ~err_any; // R15
		q_next.stage_en = ~err_any; // R15
		q_next.brake_rel = ~err_any; // R15

		// blink phase, shared by all LEDs
		if (q_reg.blink_cnt == 32'(BLINK_CYCLES - 1)) begin
			q_next.blink_cnt = '0;
			q_next.blink = ~q_reg.blink; // R23
		end else
			q_next.blink_cnt = q_reg.blink_cnt + 32'h1;

		// keys: a press waits for the window to see if a second follows
		chord = press[P_KL] & q_reg.pins[P_KR];
		if (q_reg.pend_up | q_reg.pend_dn)
			q_next.pend_cnt = q_reg.pend_cnt + 32'h1;
		if (chord) begin
			q_next.pend_up = 1'b0;
			q_next.pend_dn = 1'b0;
		end else if (press[P_KR]) begin
			if (q_reg.pend_up) begin
				act_up10 = 1'b1; // R6
				q_next.pend_up = 1'b0;
			end else begin
				act_dn = q_reg.pend_dn;
				q_next.pend_dn = 1'b0;
				q_next.pend_up = 1'b1;
				q_next.pend_cnt = '0;
			end
		end else if (press[P_KL]) begin
			if (q_reg.pend_dn) begin
				act_dn10 = 1'b1; // R8
				q_next.pend_dn = 1'b0;
			end else begin
				act_up = q_reg.pend_up;
				q_next.pend_up = 1'b0;
				q_next.pend_dn = 1'b1;
				q_next.pend_cnt = '0;
			end
		end else if ((q_reg.pend_up | q_reg.pend_dn) &&
			q_reg.pend_cnt == 32'(DOUBLE_CYCLES - 1)) begin
			act_up = q_reg.pend_up; // R24
			act_dn = q_reg.pend_dn; // R24
			q_next.pend_up = 1'b0;
			q_next.pend_dn = 1'b0;
		end

		// menu and number editing
		unique case (q_reg.mode)
			fsi_pkg::MENU_BROWSE:
			begin
				if ((act_up | act_up10) && q_reg.menu_item < 8'(NAXES))
					q_next.menu_item = q_reg.menu_item + 8'h1; // R5
				if ((act_dn | act_dn10) && q_reg.menu_item != 8'h00)
					q_next.menu_item = q_reg.menu_item - 8'h1; // R7
				if (chord && q_reg.menu_item == 8'h00) begin
					q_next.mode = fsi_pkg::MENU_EDIT;
					q_next.edit_val = q_reg.saved;
				end
			end
			fsi_pkg::MENU_EDIT:
			begin
				if (act_up)
					q_next.edit_val = step_up(q_reg.edit_val, fsi_pkg::STEP_FINE); // R5
				if (act_up10)
					q_next.edit_val = step_up(q_reg.edit_val, fsi_pkg::STEP_COARSE); // R6
				if (act_dn)
					q_next.edit_val = step_dn(q_reg.edit_val, fsi_pkg::STEP_FINE); // R7
				if (act_dn10)
					q_next.edit_val = step_dn(q_reg.edit_val, fsi_pkg::STEP_COARSE); // R8
				if (chord) begin
					q_next.saved = q_reg.edit_val; // R9
					q_next.mode = fsi_pkg::MENU_BROWSE; // R9
				end
			end
		endcase
		if (do_reset && clr_mask == '1) begin
			q_next.mode = fsi_pkg::MENU_BROWSE;
			q_next.menu_item = 8'h00;
		end

		// axis LEDs, selection first
		for (int k = 0; k < NAXES; k++) begin
			if (q_reg.menu_item == 8'(k + 1)) begin
				q_next.red[k] = q_reg.blink; // R14
				q_next.green[k] = q_reg.blink; // R14
			end else if (q_reg.pins[P_AF + k] | err_any) begin
				q_next.red[k] = 1'b1; // R10
				q_next.green[k] = 1'b0;
			end else if (q_reg.pins[P_AW + k]) begin
				q_next.red[k] = q_reg.blink; // R11
				q_next.green[k] = 1'b0;
			end else if (q_reg.pins[P_AE + k]) begin
				q_next.red[k] = 1'b0;
				q_next.green[k] = 1'b1; // R12
			end else begin
				q_next.red[k] = 1'b0;
				q_next.green[k] = q_reg.blink; // R13
			end
		end

		// host traffic forwarded by station address
		q_next.link_valid = host_valid & q_reg.addr_taken; // R1
		q_next.link_data = host_data;
		q_next.link_sel[0] = host_addr == q_reg.master_addr;
		for (int k = 0; k < NAXES; k++)
			q_next.link_sel[k + 1] = host_addr == q_reg.axis_addr[k]; // R1

		// register read data, loaded during setup
		if (psel & ~penable) begin
			q_next.rdata = '0;
			unique case (paddr)
				fsi_pkg::OFF_CONTROL: q_next.rdata[fsi_pkg::CTL_WARNF] = q_reg.warn_en;
				fsi_pkg::OFF_STATUS: q_next.rdata = {8'h00, q_reg.menu_item, 3'h0,
					q_reg.mode == fsi_pkg::MENU_EDIT, q_reg.addr_err, q_reg.brake_rel,
					q_reg.stage_en, q_reg.ready, 2'h0, q_reg.err_code};
				fsi_pkg::OFF_FAULTS: q_next.rdata = q_reg.faults;
				fsi_pkg::OFF_ADDRESS: q_next.rdata = {8'h00,
					q_reg.axis_addr[NAXES-1], q_reg.saved, q_reg.master_addr};
				fsi_pkg::OFF_EDIT: q_next.rdata = {24'h0, q_reg.edit_val};
				default: q_next.pslverr = 1'b1;
			endcase
		end
	end

	// single state register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q_reg <= '0;
		else
			q_reg <= q_next;
	end

	// outputs straight from the state register
	assign prdata = q_reg.rdata;
	assign pready = q_reg.pready;
	assign pslverr = q_reg.pslverr;
	assign link_valid = q_reg.link_valid;
	assign link_sel = q_reg.link_sel;
	assign link_data = q_reg.link_data;
	assign ready_contact = q_reg.ready;
	assign stage_enable = q_reg.stage_en;
	assign brake_release = q_reg.brake_rel;
	assign err_code = q_reg.err_code;
	assign led_red = q_reg.red;
	assign led_green = q_reg.green;
	assign axis_addr = q_reg.axis_addr;
	assign saved_addr = q_reg.saved;

	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	err_response_a: assert property (|q_reg.faults |=> !ready_contact && !stage_enable && !brake_release) else $error("error response missing"); // R15
	clear_clearable_a: assert property (do_clear && !do_reset && set_vec == '0 &&
		(q_reg.faults & ~fsi_pkg::CLEARABLE_MASK) == '0 |=> q_reg.faults == '0) else $error("clear left faults"); // R21
	clear_keeps_a: assert property (do_clear && !do_reset |=> (q_reg.faults & ~fsi_pkg::CLEARABLE_MASK)
		== ($past(q_reg.faults) & ~fsi_pkg::CLEARABLE_MASK | $past(set_vec) & ~fsi_pkg::CLEARABLE_MASK)) else $error("clear hit fixed fault"); // R21
	reserved_never_a: assert property ((q_reg.faults & fsi_pkg::RESERVED_MASK) == '0) else $error("reserved code set"); // R17
	code_none_a: assert property (q_reg.faults == '0 |=> err_code == fsi_pkg::CODE_NONE) else $error("code without fault"); // R16
	undervolt_a: assert property (bus_voltage < fsi_pkg::UNDERVOLT_V |=> q_reg.faults[fsi_pkg::BIT_UNDERVOLT]) else $error("undervoltage missed"); // R19
	checksum_a: assert property (param_sum != param_sum_ref |=> ##1 err_code != fsi_pkg::CODE_NONE || q_reg.menu_item != 8'h00) else $error("checksum fault missed"); // R18
	addr_last_a: assert property (q_reg.addr_taken |=> axis_addr[8*NAXES-1 -: 8] == q_reg.master_addr - 8'(NAXES)) else $error("last axis address wrong"); // R2
	addr_fixed_a: assert property (q_reg.addr_taken |=> $stable(q_reg.master_addr) && q_reg.addr_taken) else $error("address changed"); // R4
	select_blink_a: assert property (q_reg.menu_item == 8'h01 |=> led_red[0] == led_green[0]) else $error("selected LEDs differ"); // R14
	fault_led_a: assert property (|q_reg.faults && q_reg.menu_item != 8'h01 |=> led_red[0] && !led_green[0]) else $error("fault LED wrong"); // R10
	apb_answer_a: assert property (psel && !penable |=> pready ##1 !pready) else $error("apb answer timing"); // implementation choice: APB access timing

	clear_cov_c: cover property (do_clear && q_reg.faults != '0);
	double_cov_c: cover property (act_up10 && q_reg.mode == fsi_pkg::MENU_EDIT);
	chord_cov_c: cover property (chord && q_reg.mode == fsi_pkg::MENU_EDIT);
endmodule : fsi_top

// [panel_model.sv]
/*
 * Operator panel and host serial model: presses keys, sends host bytes.
 * Assumes the bench calls its tasks right after a rising pclk edge.
 */
`timescale 1ns/1ns
module panel_model (
	// clock
	input  wire logic       pclk,
	// operator keys
	output logic            key_right,
	output logic            key_left,
	output logic            reset_key,
	// host serial bytes
	output logic            host_valid,
	output logic [7:0]      host_addr,
	output logic [7:0]      host_data
);
	// idle panel and link at time zero
	initial
	begin
		{reset_key, key_left, key_right} = 3'h0;
		host_valid = 1'b0;
		host_addr = 8'hFF;
		host_data = 8'hFF;
	end

	// one press of the keys in mask, held for hold edges
	task tap(input logic [2:0] mask, input int hold);
		@(posedge pclk);
		{reset_key, key_left, key_right} <= mask;
		repeat (hold) @(posedge pclk);
		{reset_key, key_left, key_right} <= 3'h0;
		repeat (3) @(posedge pclk);
	endtask : tap

	// right held, then left added
	task chord;
		@(posedge pclk);
		key_right <= 1'b1;
		repeat (3) @(posedge pclk);
		key_left <= 1'b1;
		repeat (3) @(posedge pclk);
		{key_left, key_right} <= 2'h0;
		repeat (3) @(posedge pclk);
	endtask : chord

	// one host byte; released lines show the inverse afterwards
	task send(input logic [7:0] addr, input logic [7:0] data);
		@(posedge pclk);
		host_valid <= 1'b1;
		host_addr <= addr;
		host_data <= data;
		@(posedge pclk);
		host_valid <= 1'b0;
		host_addr <= ~addr;
		host_data <= ~data;
	endtask : send
endmodule : panel_model

// [tb_axis_fault_status_indicator.sv]
/*
 * Self-checking bench for the fault and status indicator over APB.
 * Assumes three axes and short blink and double-press counts.
 */
`timescale 1ns/1ns
module tb_axis_fault_status_indicator;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, addr_strap, motor_temp, host_addr, host_data, link_data, saved_addr;
	logic [31:0] pwdata, prdata, fault_in, rdata;
	logic        key_right, key_left, reset_key, host_valid, link_valid, rerr;
	logic [2:0]  axis_fault, axis_warning, axis_enabled, led_red, led_green;
	logic [9:0]  bus_voltage;
	logic [15:0] param_sum, prog_sum;
	logic [3:0]  link_sel;
	logic        ready_contact, stage_enable, brake_release;
	logic [5:0]  err_code, base;
	logic [23:0] axis_addr;
	int          failures, compares;
	logic [5:0]  codes [7] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h08, 6'h17, 6'h20};

	fsi_top #(.NAXES(3), .BLINK_CYCLES(4), .DOUBLE_CYCLES(8)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .fault_in(fault_in),
		.key_right(key_right), .key_left(key_left), .reset_key(reset_key),
		.axis_fault(axis_fault), .axis_warning(axis_warning),
		.axis_enabled(axis_enabled), .addr_strap(addr_strap),
		.bus_voltage(bus_voltage), .motor_temp(motor_temp), .param_sum(param_sum),
		.param_sum_ref(16'h0000), .prog_sum(prog_sum), .prog_sum_ref(16'h0000),
		.host_valid(host_valid), .host_addr(host_addr), .host_data(host_data),
		.link_valid(link_valid), .link_sel(link_sel), .link_data(link_data),
		.ready_contact(ready_contact), .stage_enable(stage_enable),
		.brake_release(brake_release), .err_code(err_code), .led_red(led_red),
		.led_green(led_green), .axis_addr(axis_addr), .saved_addr(saved_addr));

	panel_model u_panel (
		.pclk(pclk), .key_right(key_right), .key_left(key_left),
		.reset_key(reset_key), .host_valid(host_valid), .host_addr(host_addr),
		.host_data(host_data));

	// 125 MHz clock
	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	task stop_test;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test

	task check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// one apb transfer; waits for pready under a bound
	task apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
		int n;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, addr, data};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			failures++;
			stop_test();
		end
		rdata = prdata;
		rerr = pslverr;
		{psel, penable} <= 2'h0;
	endtask : apb

	task settle;
		repeat (10) @(posedge pclk);
	endtask : settle

	// reset request clears all latched faults
	task clear_all;
		settle(); // let cleared pins drain through the synchroniser first
		apb(1'b1, fsi_pkg::OFF_CONTROL, 32'h0000_0002);
		settle();
		check({26'h0, err_code}, 32'h0);
		check({31'h0, ready_contact}, 32'h1);
	endtask : clear_all

	task sense(input logic [9:0] v, input logic [7:0] t, input logic [15:0] ps,
		input logic [15:0] gs, input logic [5:0] exp);
		{bus_voltage, motor_temp, param_sum, prog_sum} <= {v, t, ps, gs};
		settle();
		check({26'h0, err_code}, {26'h0, exp});
		{bus_voltage, motor_temp, param_sum, prog_sum} <= {10'h0C8, 8'h19, 32'h0};
		clear_all();
	endtask : sense

	// lit count over 12 edges: 0 off, 1 steady, 2 blinking
	task leds(input int ax, input int rm, input int gm);
		int nr, ng, same;
		{nr, ng, same} = '0;
		repeat (12)
		begin
			@(posedge pclk);
			nr += led_red[ax];
			ng += led_green[ax];
			same += (led_red[ax] === led_green[ax]);
		end
		check((nr == 0) ? 0 : (nr == 12) ? 1 : 2, rm);
		check((ng == 0) ? 0 : (ng == 12) ? 1 : 2, gm);
		if (rm == 2 && gm == 2)
			check(same, 12);
	endtask : leds

	task edit_step(input logic [2:0] mask, input int n, input logic [7:0] exp);
		repeat (n) u_panel.tap(mask, 2);
		repeat (20) @(posedge pclk);
		apb(1'b0, fsi_pkg::OFF_EDIT, 32'h0);
		check(rdata & 32'hFF, {24'h0, exp});
	endtask : edit_step

	// main sequence
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{fault_in, axis_fault, axis_warning, axis_enabled} = '0;
		{param_sum, prog_sum} = '0;
		addr_strap = 8'h0A;
		bus_voltage = 10'h0C8;
		motor_temp = 8'h19;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (14) @(posedge pclk);
		check({8'h0, axis_addr}, 32'h0007_0809);
		addr_strap <= 8'h20;
		apb(1'b0, fsi_pkg::OFF_ADDRESS, 32'h0);
		check(rdata & 32'h00FF_00FF, 32'h0007_000A);
		$display("test addressing done");
		apb(1'b0, 8'h40, 32'h0);
		check({rerr, rdata[30:0]}, 32'h8000_0000);
		apb(1'b1, fsi_pkg::OFF_CONTROL, 32'h4);
		apb(1'b0, fsi_pkg::OFF_CONTROL, 32'h0);
		check(rdata & 32'h4, 32'h4);
		apb(1'b1, fsi_pkg::OFF_CONTROL, 32'h0);
		$display("test registers done");
		foreach (codes[i])
		begin
			fault_in <= 32'h1 << (codes[i] - 6'h01);
			settle();
			check({26'h0, err_code}, {26'h0, codes[i]});
			check({ready_contact, stage_enable, brake_release}, 32'h0);
			apb(1'b0, fsi_pkg::OFF_FAULTS, 32'h0);
			check(rdata, 32'h1 << (codes[i] - 6'h01));
			fault_in <= 32'h0;
			clear_all();
		end
		fault_in <= 32'h0420_0000;
		settle();
		check({26'h0, err_code}, 32'h0);
		fault_in <= 32'h0;
		sense(10'h064, 8'h91, 16'h0, 16'h0, 6'h00);
		sense(10'h063, 8'h19, 16'h0, 16'h0, 6'h05);
		sense(10'h0C8, 8'h92, 16'h0, 16'h0, 6'h06);
		sense(10'h0C8, 8'h19, 16'h1, 16'h0, 6'h09);
		sense(10'h0C8, 8'h19, 16'h0, 16'h1, 6'h0A);
		$display("test fault codes done");
		fault_in <= 32'h2;
		settle();
		fault_in <= 32'h0;
		settle();
		apb(1'b1, fsi_pkg::OFF_CONTROL, 32'h1);
		settle();
		check({26'h0, err_code}, 32'h0);
		fault_in <= 32'h8;
		settle();
		fault_in <= 32'h0;
		settle();
		apb(1'b1, fsi_pkg::OFF_CONTROL, 32'h1);
		settle();
		check({26'h0, err_code}, 32'h4);
		u_panel.tap(3'b100, 3);
		settle();
		check({26'h0, err_code}, 32'h0);
		apb(1'b1, fsi_pkg::OFF_CONTROL, 32'h4);
		axis_warning <= 3'b001;
		settle();
		check({25'h0, err_code, ready_contact}, 32'h30);
		axis_warning <= 3'b000;
		clear_all();
		$display("test clearing done");
		{axis_enabled, axis_warning} <= {3'b001, 3'b100};
		settle();
		leds(0, 0, 1);
		leds(1, 0, 2);
		leds(2, 2, 0);
		axis_fault <= 3'b010;
		settle();
		leds(1, 1, 0);
		{axis_fault, axis_warning} <= '0;
		clear_all();
		$display("test leds done");
		u_panel.tap(3'b001, 3);
		repeat (20) @(posedge pclk);
		apb(1'b0, fsi_pkg::OFF_STATUS, 32'h0);
		check(rdata & 32'hFF_0000, 32'h01_0000);
		leds(0, 2, 2);
		u_panel.tap(3'b010, 3);
		repeat (20) @(posedge pclk);
		apb(1'b0, fsi_pkg::OFF_STATUS, 32'h0);
		check(rdata & 32'hFF_0000, 32'h0);
		u_panel.chord();
		repeat (20) @(posedge pclk);
		apb(1'b0, fsi_pkg::OFF_STATUS, 32'h0);
		check(rdata & 32'h1000, 32'h1000);
		apb(1'b0, fsi_pkg::OFF_EDIT, 32'h0);
		base = rdata[5:0];
		edit_step(3'b001, 1, {2'h0, base} + 8'h01);
		edit_step(3'b001, 2, {2'h0, base} + 8'h0B);
		edit_step(3'b010, 2, {2'h0, base} + 8'h01);
		edit_step(3'b010, 1, {2'h0, base});
		edit_step(3'b001, 1, {2'h0, base} + 8'h01);
		u_panel.chord();
		repeat (20) @(posedge pclk);
		check({24'h0, saved_addr}, {24'h0, {2'h0, base} + 8'h01});
		$display("test panel done");
		u_panel.send(8'h08, 8'h5A);
		@(posedge pclk);
		check({19'h0, link_valid, link_sel, link_data}, 32'h145A);
		u_panel.send(8'h0A, 8'hC3);
		@(posedge pclk);
		check({19'h0, link_valid, link_sel, link_data}, 32'h11C3);
		$display("test host link done");
		stop_test();
	end

	// watchdog
	initial
	begin
		repeat (30000) @(posedge pclk);
		failures++;
		stop_test();
	end
endmodule : tb_axis_fault_status_indicator
